// ===== core/acps_defs.vh
// register map, field positions, reset values and timing for the action scheduler
`ifndef ACPS_DEFS_VH
`define ACPS_DEFS_VH

`define ACPS_AW            12
`define ACPS_OFF_CTRL      12'h000
`define ACPS_OFF_STATUS    12'h004
`define ACPS_OFF_DEV_KEY   12'h008
`define ACPS_OFF_GRP_ID    12'h00C
`define ACPS_OFF_GRP_MASK  12'h010
`define ACPS_OFF_SLOT      12'h014
`define ACPS_OFF_QCAP      12'h018
`define ACPS_OFF_CAP_LO    12'h01C
`define ACPS_OFF_CAP_HI    12'h020
`define ACPS_OFF_DELAY     12'h024
`define ACPS_OFF_TIME_LO   12'h028
`define ACPS_OFF_TIME_HI   12'h02C

`define ACPS_CTRL_PTP_EN   0
`define ACPS_CTRL_CLR      1
`define ACPS_CTRL_CAP      2
`define ACPS_CTRL_RESTART  3
`define ACPS_CTRL_OPEN     4
`define ACPS_CTRL_CLOSE    5

`define ACPS_ST_SYNCED     0
`define ACPS_ST_MASTER     1
`define ACPS_ST_BULK       2
`define ACPS_ST_DROP       3
`define ACPS_ST_QCNT       8

`define ACPS_RST_DEV_KEY   32'h00000000
`define ACPS_RST_GRP_ID    32'h00000000
`define ACPS_RST_GRP_MASK  32'h00000000
`define ACPS_SLOT_INDEX    32'h00000000

`define ACPS_CLK_NS        10
`define ACPS_SYNC_MS       1000
`define ACPS_SYNC_CYCLES   (`ACPS_SYNC_MS * 1000000 / `ACPS_CLK_NS)

`endif

// ===== core/acps_top.v
// action command filter, scheduled exposure queue and ptp time slave
//
// Added by the designer: the APB interface to the registers and the register addresses.
`include "acps_defs.vh"

module acps_top #(
    parameter TW            = 64,
    parameter QDEPTH        = 4,
    parameter QAW           = 2,
    parameter SYNC_INTERVAL = `ACPS_SYNC_CYCLES,
    parameter LOCAL_QUALITY = 8'h80,
    parameter LOCAL_MAC     = 48'h02000000000A  // arbitrary value
) (
    input  wire                clk_sys,
    input  wire                arst_n,
    input  wire                clk_en,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [`ACPS_AW-1:0] paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output reg                 pready,
    output reg                 pslverr,
    input  wire                cmd_valid,
    input  wire [31:0]         cmd_device_key,
    input  wire [31:0]         cmd_group_id,
    input  wire [31:0]         cmd_group_bitmask,
    input  wire                cmd_has_time,
    input  wire [TW-1:0]       cmd_time,
    input  wire                ann_valid,
    input  wire [7:0]          ann_quality,
    input  wire [47:0]         ann_mac,
    input  wire                ts_valid,
    input  wire [TW-1:0]       ts_t1,
    input  wire [TW-1:0]       ts_t2,
    input  wire [TW-1:0]       ts_t3,
    input  wire [TW-1:0]       ts_t4,
    output reg                 sync_request,
    output reg                 exposure_start,
    output reg                 ptp_synced
);

    localparam [TW-1:0] TICK = `ACPS_CLK_NS;
    wire       [31:0]   qd32 = QDEPTH;
    wire       [QAW:0]  qfull = qd32[QAW:0];

    // apb strobes
    wire acc   = psel & penable & pready;
    wire wr    = acc & pwrite;
    wire wctrl = wr & (paddr == `ACPS_OFF_CTRL);
    wire cmd_clr   = wctrl & pwdata[`ACPS_CTRL_CLR];
    wire cmd_cap   = wctrl & pwdata[`ACPS_CTRL_CAP];
    wire cmd_rst   = wctrl & pwdata[`ACPS_CTRL_RESTART];
    wire cmd_open  = wctrl & pwdata[`ACPS_CTRL_OPEN];
    wire cmd_close = wctrl & pwdata[`ACPS_CTRL_CLOSE];

    reg          restart;
    reg          ptp_sync_enable;
    reg          bulk_active;
    reg [31:0]   camera_target_key;
    reg [31:0]   stage_group_id;
    reg [31:0]   stage_group_bitmask;
    reg [31:0]   command_group_id;
    reg [31:0]   command_group_bitmask;
    reg [TW-1:0] time_now;
    reg [TW-1:0] captured_time_value;
    reg [TW-1:0] path_delay;
    reg [TW-1:0] offset;
    reg [TW-1:0] diff_ms;
    reg [TW-1:0] diff_sm;
    reg          s1_valid;
    reg          corr_valid;
    reg [7:0]    best_quality;
    reg [47:0]   best_mac;
    reg [31:0]   interval_cnt;
    reg          drop_seen;

    // queue storage
    reg [TW-1:0] q_time [0:QDEPTH-1];
    reg [QAW-1:0] wr_ptr;
    reg [QAW-1:0] rd_ptr;
    reg [QAW:0]   q_cnt;

    wire is_master = (best_mac == LOCAL_MAC);

    // command filter
    wire key_ok  = (cmd_device_key == camera_target_key);
    wire grp_ok  = (cmd_group_id == command_group_id);
    wire mask_ok = |(cmd_group_bitmask & command_group_bitmask);
    wire accept  = cmd_valid & ptp_synced & key_ok & grp_ok & mask_ok;
    wire q_full  = (q_cnt == qfull);
    wire push    = accept & cmd_has_time & ~q_full;
    wire drop    = accept & cmd_has_time & q_full;
    wire pop     = (q_cnt != {(QAW+1){1'b0}}) & (time_now >= q_time[rd_ptr]);

    // delay and offset arithmetic
    wire [TW:0] sum_d = {diff_ms[TW-1], diff_ms} + {diff_sm[TW-1], diff_sm};
    wire [TW:0] dif_o = {diff_ms[TW-1], diff_ms} - {diff_sm[TW-1], diff_sm};

    // announce comparison
    wire better = (ann_quality < best_quality) |
                  ((ann_quality == best_quality) & (ann_mac < best_mac));

    // apb handshake, one wait state
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
        end else if (clk_en) begin
            pready <= psel & penable & ~pready;
        end
    end

    reg [31:0] rd_mux;
    reg        rd_err;
    always @* begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        case (paddr)
            `ACPS_OFF_CTRL:     rd_mux = {31'h00000000, ptp_sync_enable};
            `ACPS_OFF_STATUS: begin
                rd_mux[`ACPS_ST_SYNCED] = ptp_synced;
                rd_mux[`ACPS_ST_MASTER] = is_master;
                rd_mux[`ACPS_ST_BULK]   = bulk_active;
                rd_mux[`ACPS_ST_DROP]   = drop_seen;
                rd_mux[`ACPS_ST_QCNT+QAW:`ACPS_ST_QCNT] = q_cnt;
            end
            `ACPS_OFF_DEV_KEY:  rd_mux = camera_target_key;
            `ACPS_OFF_GRP_ID:   rd_mux = stage_group_id;
            `ACPS_OFF_GRP_MASK: rd_mux = stage_group_bitmask;
            `ACPS_OFF_SLOT:     rd_mux = `ACPS_SLOT_INDEX;
            `ACPS_OFF_QCAP:     rd_mux = qd32;
            `ACPS_OFF_CAP_LO:   rd_mux = captured_time_value[31:0];
            `ACPS_OFF_CAP_HI:   rd_mux = captured_time_value[TW-1:32];
            `ACPS_OFF_DELAY:    rd_mux = path_delay[31:0];
            `ACPS_OFF_TIME_LO:  rd_mux = time_now[31:0];
            `ACPS_OFF_TIME_HI:  rd_mux = time_now[TW-1:32];
            default:            rd_err = 1'b1;
        endcase
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            if (psel & penable & ~pready) begin
                prdata  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= rd_err;
            end else begin
                prdata  <= 32'h00000000;
                pslverr <= 1'b0;
            end
        end
    end

    // device restart pulse
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            restart <= 1'b0;
        end else if (clk_en) begin
            restart <= cmd_rst & ~restart;
        end
    end

    // configuration registers
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ptp_sync_enable       <= 1'b0;
            bulk_active           <= 1'b0;
            camera_target_key     <= `ACPS_RST_DEV_KEY;
            stage_group_id        <= `ACPS_RST_GRP_ID;
            stage_group_bitmask   <= `ACPS_RST_GRP_MASK;
            command_group_id      <= `ACPS_RST_GRP_ID;
            command_group_bitmask <= `ACPS_RST_GRP_MASK;
            captured_time_value   <= {TW{1'b0}};
        end else if (clk_en) begin
            if (restart) begin
                ptp_sync_enable       <= 1'b0;
                bulk_active           <= 1'b0;
                camera_target_key     <= `ACPS_RST_DEV_KEY;
                stage_group_id        <= `ACPS_RST_GRP_ID;
                stage_group_bitmask   <= `ACPS_RST_GRP_MASK;
                command_group_id      <= `ACPS_RST_GRP_ID;
                command_group_bitmask <= `ACPS_RST_GRP_MASK;
                captured_time_value   <= {TW{1'b0}};
            end else begin
                if (wctrl) begin
                    ptp_sync_enable <= pwdata[`ACPS_CTRL_PTP_EN];
                end
                if (cmd_open) begin
                    bulk_active <= 1'b1;
                end else if (cmd_close) begin
                    bulk_active <= 1'b0;
                end
                if (wr & (paddr == `ACPS_OFF_DEV_KEY)) begin
                    camera_target_key <= pwdata;
                end
                if (wr & (paddr == `ACPS_OFF_GRP_ID)) begin
                    stage_group_id <= pwdata;
                end
                if (wr & (paddr == `ACPS_OFF_GRP_MASK)) begin
                    stage_group_bitmask <= pwdata;
                end
                if (~bulk_active) begin
                    command_group_id      <= stage_group_id;
                    command_group_bitmask <= stage_group_bitmask;
                end
                if (cmd_cap) begin
                    captured_time_value <= time_now;
                end
            end
        end
    end

    // best master selection
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            best_quality <= LOCAL_QUALITY;
            best_mac     <= LOCAL_MAC;
        end else if (clk_en) begin
            if (restart | ~ptp_sync_enable) begin
                best_quality <= LOCAL_QUALITY;
                best_mac     <= LOCAL_MAC;
            end else if (ann_valid & better) begin
                best_quality <= ann_quality;
                best_mac     <= ann_mac;
            end
        end
    end

    // delay request interval
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            interval_cnt <= 32'h00000000;
            sync_request <= 1'b0;
        end else if (clk_en) begin
            if (restart | ~ptp_sync_enable | is_master) begin
                interval_cnt <= 32'h00000000;
                sync_request <= 1'b0;
            end else if (interval_cnt == 32'h00000000) begin
                interval_cnt <= SYNC_INTERVAL - 1;
                sync_request <= 1'b1;
            end else begin
                interval_cnt <= interval_cnt - 32'h00000001;
                sync_request <= 1'b0;
            end
        end
    end

    // timestamp exchange, two stages
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            diff_ms    <= {TW{1'b0}};
            diff_sm    <= {TW{1'b0}};
            s1_valid   <= 1'b0;
            path_delay <= {TW{1'b0}};
            offset     <= {TW{1'b0}};
            corr_valid <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                s1_valid   <= 1'b0;
                corr_valid <= 1'b0;
                path_delay <= {TW{1'b0}};
                offset     <= {TW{1'b0}};
            end else begin
                s1_valid <= ts_valid & ptp_sync_enable & ~is_master;
                if (ts_valid) begin
                    diff_ms <= ts_t2 - ts_t1;
                    diff_sm <= ts_t4 - ts_t3;
                end
                corr_valid <= s1_valid & ptp_sync_enable & ~is_master;
                if (s1_valid) begin
                    path_delay <= sum_d[TW:1];
                    offset     <= dif_o[TW:1];
                end
            end
        end
    end

    // local time counter in ns
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            time_now <= {TW{1'b0}};
        end else if (clk_en) begin
            if (restart | cmd_clr) begin
                time_now <= {TW{1'b0}};
            end else if (corr_valid) begin
                time_now <= time_now - offset + TICK;
            end else begin
                time_now <= time_now + TICK;
            end
        end
    end

    // sync state
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ptp_synced <= 1'b0;
        end else if (clk_en) begin
            if (restart | ~ptp_sync_enable) begin
                ptp_synced <= 1'b0;
            end else if (ann_valid & better) begin
                ptp_synced <= 1'b0;
            end else if (is_master | corr_valid) begin
                ptp_synced <= 1'b1;
            end
        end
    end

    // scheduled queue pointers
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr    <= {QAW{1'b0}};
            rd_ptr    <= {QAW{1'b0}};
            q_cnt     <= {(QAW+1){1'b0}};
            drop_seen <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                wr_ptr    <= {QAW{1'b0}};
                rd_ptr    <= {QAW{1'b0}};
                q_cnt     <= {(QAW+1){1'b0}};
                drop_seen <= 1'b0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
                if (push & ~pop) begin
                    q_cnt <= q_cnt + 1'b1;
                end else if (pop & ~push) begin
                    q_cnt <= q_cnt - 1'b1;
                end
                if (drop) begin
                    drop_seen <= 1'b1;
                end else if (wctrl & pwdata[`ACPS_CTRL_CLR]) begin
                    drop_seen <= 1'b0;
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (clk_en & push) begin
            q_time[wr_ptr] <= cmd_time;
        end
    end

    // exposure start pulse
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            exposure_start <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                exposure_start <= 1'b0;
            end else begin
                exposure_start <= (accept & ~cmd_has_time) | pop;
            end
        end
    end

endmodule // acps_top

// ===== bench/acps_top_sva.sv
// port checker for the action command scheduler
`include "acps_defs.vh"
module acps_top_sva #(
    parameter QDEPTH = 4
) (
    input logic                clk_sys,
    input logic                arst_n,
    input logic                clk_en,
    input logic                psel,
    input logic                penable,
    input logic                pwrite,
    input logic [`ACPS_AW-1:0] paddr,
    input logic [31:0]         pwdata,
    input logic [31:0]         prdata,
    input logic                pready,
    input logic                pslverr,
    input logic                ts_valid,
    input logic                sync_request,
    input logic                exposure_start,
    input logic                ptp_synced
);
    localparam logic [31:0] QCAP_V = QDEPTH;
    wire ctrl_wr = psel && penable && pready && pwrite && (paddr == `ACPS_OFF_CTRL);
    wire rd_done = psel && penable && pready && !pwrite;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_apb_wait: assert property (psel && !penable && clk_en |=> !pready ##1 pready)
        else $error("pready not on second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside ready cycle");
    a_unmapped_err: assert property (pready && psel && paddr > `ACPS_OFF_TIME_HI |-> pslverr)
        else $error("no error for unmapped address");
    a_slot_zero: assert property (rd_done && paddr == `ACPS_OFF_SLOT |-> prdata == `ACPS_SLOT_INDEX)
        else $error("slot index not zero");
    a_qcap_value: assert property (rd_done && paddr == `ACPS_OFF_QCAP |-> prdata == QCAP_V)
        else $error("queue capacity wrong");
    a_restart_clear: assert property (ctrl_wr && pwdata[`ACPS_CTRL_RESTART] |-> ##3 !ptp_synced && !exposure_start && !sync_request)
        else $error("state kept after restart");
    a_disable_drop: assert property (ctrl_wr && !pwdata[`ACPS_CTRL_PTP_EN] |-> ##2 !ptp_synced [*2])
        else $error("synced while disabled");

    c_expose: cover property (exposure_start);
    c_sync_rise: cover property ($rose(ptp_synced));
    c_exchange: cover property (sync_request ##[1:12] ts_valid);
    c_err: cover property (pready && pslverr);
endmodule // acps_top_sva

// ===== bench/acps_peer_model.sv
// peer clock model: announces and timestamped delay exchange
module acps_peer_model #(
    parameter TW  = 64,
    parameter DLY = 200
) (
    input  logic          clk_sys,
    input  logic          sync_request,
    input  logic          slow,
    output logic          ts_valid,
    output logic [TW-1:0] ts_t1,
    output logic [TW-1:0] ts_t2,
    output logic [TW-1:0] ts_t3,
    output logic [TW-1:0] ts_t4,
    output logic          ann_valid,
    output logic [7:0]    ann_quality,
    output logic [47:0]   ann_mac
);
    logic [TW-1:0] master_time = '0;
    always @(posedge clk_sys) master_time <= master_time + 10;
    task automatic announce(input logic [7:0] q, input logic [47:0] mac);
        @(posedge clk_sys);
        ann_valid <= 1'b1;
        ann_quality <= q;
        ann_mac <= mac;
        @(posedge clk_sys);
        ann_valid <= 1'b0;
        ann_quality <= ~q;
        ann_mac <= ~mac;
    endtask
    initial begin
        ts_valid = 1'b0;
        ann_valid = 1'b0;
        ann_quality = 8'hFF;
        ann_mac = 48'h0;
        forever begin
            @(posedge clk_sys);
            if (sync_request === 1'b1) begin
                repeat (slow ? 8 : 1) @(posedge clk_sys);
                ts_valid <= 1'b1;
                ts_t1 <= master_time;
                ts_t2 <= master_time + DLY;
                ts_t3 <= master_time + DLY + 50;
                ts_t4 <= master_time + 2 * DLY + 50;
                @(posedge clk_sys);
                ts_valid <= 1'b0;
                ts_t1 <= ~ts_t1;
                ts_t2 <= ~ts_t2;
                ts_t3 <= ~ts_t3;
                ts_t4 <= ~ts_t4;
            end
        end
    end
endmodule // acps_peer_model

// ===== bench/tb_top.sv
// testbench for the action command scheduler
`include "acps_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QDEPTH = 4;
    logic        clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv, t0, t1;
    logic        pready, pslverr, er, ts_valid, ann_valid, sync_request, exposure_start, ptp_synced;
    logic        cmd_valid = 1'b0, cmd_has_time = 1'b0, peer_slow = 1'b0, clk_en = 1'b1;
    logic [31:0] cmd_device_key = 32'h0, cmd_group_id = 32'h0, cmd_group_bitmask = 32'h0;
    logic [63:0] cmd_time = 64'h0, ts_t1, ts_t2, ts_t3, ts_t4;
    logic [7:0]  ann_quality;
    logic [47:0] ann_mac;
    int          mismatches = 0, tests_run = 0, cnt;

    acps_top #(.SYNC_INTERVAL(20)) u_acps_top (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
        .cmd_device_key(cmd_device_key), .cmd_group_id(cmd_group_id), .cmd_group_bitmask(cmd_group_bitmask),
        .cmd_has_time(cmd_has_time), .cmd_time(cmd_time), .ann_valid(ann_valid), .ann_quality(ann_quality),
        .ann_mac(ann_mac), .ts_valid(ts_valid), .ts_t1(ts_t1), .ts_t2(ts_t2), .ts_t3(ts_t3), .ts_t4(ts_t4),
        .sync_request(sync_request), .exposure_start(exposure_start), .ptp_synced(ptp_synced));
    acps_peer_model u_acps_peer_model (.clk_sys(clk_sys), .sync_request(sync_request), .slow(peer_slow),
        .ts_valid(ts_valid), .ts_t1(ts_t1), .ts_t2(ts_t2), .ts_t3(ts_t3), .ts_t4(ts_t4),
        .ann_valid(ann_valid), .ann_quality(ann_quality), .ann_mac(ann_mac));

    initial forever #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) mismatches++;
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask
    task automatic send(input logic [31:0] k, g, m, input logic h, input logic [63:0] t);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_device_key <= k;
        cmd_group_id <= g;
        cmd_group_bitmask <= m;
        cmd_has_time <= h;
        cmd_time <= t;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_device_key <= ~k;
        cmd_group_id <= ~g;
        cmd_group_bitmask <= ~m;
        cmd_time <= ~t;
        #1;
    endtask
    task automatic act(input logic [31:0] k, g, m, input logic exp);
        send(k, g, m, 1'b0, 64'h0);
        chk(exposure_start, exp);
    endtask
    task automatic count(input logic which, input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if ((which ? sync_request : exposure_start) === 1'b1) cnt++;
        end
    endtask
    task automatic wait_ts();
        int n;
        n = 0;
        while (ts_valid !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic ann(input logic [7:0] q, input logic [47:0] mac);
        u_acps_peer_model.announce(q, mac);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd_chk(`ACPS_OFF_CTRL, 32'h0);
        rd_chk(`ACPS_OFF_DEV_KEY, `ACPS_RST_DEV_KEY);
        rd_chk(`ACPS_OFF_GRP_ID, `ACPS_RST_GRP_ID);
        rd_chk(`ACPS_OFF_GRP_MASK, `ACPS_RST_GRP_MASK);
        rd_chk(`ACPS_OFF_QCAP, QDEPTH);
        apb(1'b1, 12'h100, 32'h1);
        chk(er, 1'b1);
        apb(1'b1, `ACPS_OFF_SLOT, 32'hFFFFFFFF);
        chk(er, 1'b0);
        rd_chk(`ACPS_OFF_SLOT, 32'h0);
        apb(1'b1, `ACPS_OFF_DEV_KEY, 32'hA5);
        rd_chk(`ACPS_OFF_DEV_KEY, 32'hA5);
        apb(1'b1, `ACPS_OFF_GRP_ID, 32'h5);
        apb(1'b1, `ACPS_OFF_GRP_MASK, 32'h80000F00);
        act(32'hA5, 32'h5, 32'h80000000, 1'b0);
        apb(1'b1, `ACPS_OFF_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(ptp_synced, 1'b1);
        ann(8'h10, 48'h50);
        chk(ptp_synced, 1'b0);
        repeat (20) @(posedge clk_sys);
        chk(ptp_synced, 1'b1);
        rd_chk(`ACPS_OFF_DELAY, 32'd200);
        peer_slow <= 1'b1;
        count(1'b1, 100);
        chk(cnt, 5);
        wait_ts();
        ann(8'h10, 48'h60);
        chk(ptp_synced, 1'b1);
        ann(8'h90, 48'h01);
        chk(ptp_synced, 1'b1);
        wait_ts();
        ann(8'h10, 48'h40);
        chk(ptp_synced, 1'b0);
        repeat (40) @(posedge clk_sys);
        chk(ptp_synced, 1'b1);
        act(32'hA5, 32'h5, 32'h80000000, 1'b1);
        act(32'hA5, 32'h6, 32'h00000100, 1'b0);
        act(32'hA5, 32'h5, 32'h000000FF, 1'b0);
        act(32'hA6, 32'h5, 32'h00000100, 1'b0);
        act(32'hA5, 32'h5, 32'h00000100, 1'b1);
        apb(1'b1, `ACPS_OFF_CTRL, 32'h11);
        apb(1'b0, `ACPS_OFF_STATUS, 32'h0);
        chk(rv[`ACPS_ST_BULK], 1'b1);
        chk(rv[`ACPS_ST_MASTER], 1'b0);
        chk(rv[`ACPS_ST_SYNCED], 1'b1);
        apb(1'b1, `ACPS_OFF_GRP_ID, 32'h6);
        act(32'hA5, 32'h6, 32'h00000100, 1'b0);
        act(32'hA5, 32'h5, 32'h00000100, 1'b1);
        apb(1'b1, `ACPS_OFF_CTRL, 32'h21);
        repeat (2) @(posedge clk_sys);
        act(32'hA5, 32'h6, 32'h00000100, 1'b1);
        apb(1'b0, `ACPS_OFF_TIME_LO, 32'h0);
        for (int i = 0; i < 5; i++) send(32'hA5, 32'h6, 32'h100, 1'b1, {32'h0, rv + 32'd3000});
        apb(1'b0, `ACPS_OFF_STATUS, 32'h0);
        chk(rv[10:8], 3'd4);
        chk(rv[`ACPS_ST_DROP], 1'b1);
        count(1'b0, 200);
        chk(cnt, 0);
        count(1'b0, 200);
        chk(cnt, 4);
        apb(1'b1, `ACPS_OFF_CTRL, 32'h3);
        apb(1'b1, `ACPS_OFF_CTRL, 32'h5);
        apb(1'b0, `ACPS_OFF_CAP_LO, 32'h0);
        chk(rv != 32'h0 && rv < 32'd100, 1'b1);
        rd_chk(`ACPS_OFF_CAP_LO, rv);
        rd_chk(`ACPS_OFF_CAP_HI, 32'h0);
        apb(1'b0, `ACPS_OFF_TIME_LO, 32'h0);
        t0 = rv;
        apb(1'b0, `ACPS_OFF_TIME_LO, 32'h0);
        t0 = rv - t0;
        t1 = rv;
        clk_en <= 1'b0;
        repeat (10) @(posedge clk_sys);
        clk_en <= 1'b1;
        apb(1'b0, `ACPS_OFF_TIME_LO, 32'h0);
        chk(rv - t1, t0);
        apb(1'b1, `ACPS_OFF_CTRL, 32'h8);
        repeat (3) @(posedge clk_sys);
        chk(ptp_synced, 1'b0);
        rd_chk(`ACPS_OFF_DEV_KEY, 32'h0);
        rd_chk(`ACPS_OFF_CTRL, 32'h0);
        give_verdict();
    end
endmodule // tb_top

bind acps_top acps_top_sva #(.QDEPTH(QDEPTH)) u_acps_top_sva (.clk_sys(clk_sys), .arst_n(arst_n),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ts_valid(ts_valid), .sync_request(sync_request),
    .exposure_start(exposure_start), .ptp_synced(ptp_synced));
